// >>> include/feeder_pkg.sv
// Purpose: shared constants of the line feeder host port
// Assumes: 4-bit host data bus, four lines, 3-bit indirect pointer
// Notes:   pointer locations 0..3 hold per-line status words
package feeder_pkg;
   localparam int NLINES = 4;
   localparam int DATA_W = 4;
   localparam int PTR_W  = 3;

   // host addresses selected by the address select bit
   localparam logic ADDR_PTR  = 1'b0;
   localparam logic ADDR_DATA = 1'b1;

   // indirect locations beyond the four line status words
   localparam logic [PTR_W-1:0] LOC_LINE_ENABLE = 3'h4;
   localparam logic [PTR_W-1:0] LOC_OVL_FLAGS   = 3'h5;
   localparam logic [PTR_W-1:0] LOC_INT_MASK    = 3'h6;

   // field positions
   localparam int ST_LOW_VOLT  = 0;
   localparam int ST_OPEN_LOOP = 1;
   localparam int ST_CUR_OVL   = 2;
   localparam int ST_THERM_OVL = 3;
   localparam int PTR_CMD_BIT  = 3; // write to address 0 with this bit set loads the mask
   localparam int MASK_BIT     = 0;
   localparam int THERM_BIT    = 3; // thermal summary in the address 0 read word

   // reset values
   localparam logic [PTR_W-1:0]  PTR_RST     = 3'h0;
   localparam logic [NLINES-1:0] LINE_EN_RST = 4'h0;
   localparam logic              MASK_RST    = 1'b0;
   // pin synchroniser idle: reset 0, ale 1, cs/rd/wr high, rest 0
   localparam logic [25:0]       SYNC_RST = 26'h1E00000;
endpackage

// >>> include/read_port_if.sv
// Purpose: carries device state to the read word selector
// Assumes: all signals on the core clock
// Notes:   rdata is a register inside the selector
interface read_port_if;
   import feeder_pkg::*;
   logic                ce;
   logic                addr;
   logic [PTR_W-1:0]    ptr;
   logic [NLINES-1:0]   low_volt;
   logic [NLINES-1:0]   open_loop;
   logic [NLINES-1:0]   cur_ovl;
   logic [NLINES-1:0]   therm_ovl;
   logic [NLINES-1:0]   line_en;
   logic [NLINES-1:0]   ovl_flags;
   logic                int_mask;
   logic [DATA_W-1:0]   rdata;

   modport core (output ce, addr, ptr, low_volt, open_loop, cur_ovl, therm_ovl,
                 line_en, ovl_flags, int_mask, input rdata);
   modport sel  (input ce, addr, ptr, low_volt, open_loop, cur_ovl, therm_ovl,
                 line_en, ovl_flags, int_mask, output rdata);
endinterface

// >>> rtl/read_select.sv
// Purpose: registered selection of the word presented on a host read
// Assumes: inputs already synchronised to the core clock
// Notes:   one cycle from pointer or address change to new word
module read_select
   import feeder_pkg::*;
(
   // clock and reset
   input  wire logic   clk,
   input  wire logic   rst,
   // state from the core
   read_port_if.sel    rp
);
   logic [1:0] line_idx;

   assign line_idx = rp.ptr[1:0];

   // word selected by address select bit and pointer
   always_ff @(posedge clk) begin
      if (rst) begin
         rp.rdata <= 4'h0;
      end else if (rp.ce) begin
         if (rp.addr == ADDR_PTR) begin
            rp.rdata <= {|rp.therm_ovl, rp.ptr};
         end else begin
            case (rp.ptr)
               3'h0, 3'h1, 3'h2, 3'h3: begin
                  // all zero reads as a normal line
                  rp.rdata <= {rp.therm_ovl[line_idx], rp.cur_ovl[line_idx],
                               rp.open_loop[line_idx], rp.low_volt[line_idx]};
               end
               LOC_LINE_ENABLE: rp.rdata <= rp.line_en;
               LOC_OVL_FLAGS:   rp.rdata <= rp.ovl_flags;
               LOC_INT_MASK:    rp.rdata <= {3'h0, rp.int_mask};
               default:         rp.rdata <= 4'h0;
            endcase
         end
      end
   end
endmodule

// >>> rtl/line_feeder_host_interface.sv
// Purpose: host port, line enables and overload interrupt of a four line feeder
// Assumes: pins are asynchronous and pass two flip-flops; I_CE freezes all state
// Notes:   device held in reset by I_NRST low or by the reset pin high
//
// Summary of operation
// - latch transparent while strobe high, holds after
// - read and write strobes ignored unless chip select low
// - data bit 0 least significant, high is one
// - sample on write, drive on read, float otherwise
// - interrupt low while any overload flag set
// - interrupt unlatched, releases when flags clear
// - interrupt releases on thermal or host shutoff
// - overload interrupt maskable through pointer writes
// - reset keeps interrupt inactive
// - address 0 read gives pointer and thermal
// - address 1 read gives pointed location
// - reset clears registers, switches all off
// - each line's condition readable
// - four individually controlled line switches
// - write loads line enables, pointer or interrupt mask
module line_feeder_host_interface
   import feeder_pkg::*;
(
   // clock, reset, enable
   input  wire logic                          I_CORE_CLK,
   input  wire logic                          I_NRST,
   input  wire logic                          I_CE,
   // host bus pins
   input  wire logic                          I_RESET,
   input  wire logic                          I_ALE,
   input  wire logic                          I_CS_N,
   input  wire logic                          I_RD_N,
   input  wire logic                          I_WR_N,
   input  wire logic                          I_ADDR_SELECT_BIT,
   input  wire logic [feeder_pkg::DATA_W-1:0] I_HOST_DATA_BUS,
   output logic      [feeder_pkg::DATA_W-1:0] O_HOST_DATA_BUS,
   output logic                               O_HOST_DATA_OE,
   // open-drain interrupt
   output logic                               O_INT_N,
   output logic                               O_INT_OE,
   // line detectors
   input  wire logic [feeder_pkg::NLINES-1:0] I_LOW_VOLT,
   input  wire logic [feeder_pkg::NLINES-1:0] I_OPEN_LOOP,
   input  wire logic [feeder_pkg::NLINES-1:0] I_CUR_OVL,
   input  wire logic [feeder_pkg::NLINES-1:0] I_THERM_OVL,
   // line switches
   output logic      [feeder_pkg::NLINES-1:0] O_LINE_SWITCH_OUT
);
   import feeder_pkg::*;

   // synchroniser stages
   logic [25:0]        sync1_r;
   logic [25:0]        sync2_r;
   // synchronised pins
   logic               reset_s;
   logic               ale_s;
   logic               cs_n_s;
   logic               rd_n_s;
   logic               wr_n_s;
   logic               asel_s;
   logic [DATA_W-1:0]  data_s;
   logic [NLINES-1:0]  low_volt_s;
   logic [NLINES-1:0]  open_loop_s;
   logic [NLINES-1:0]  cur_ovl_s;
   logic [NLINES-1:0]  therm_ovl_s;
   // device state
   logic               rst;
   logic               addr_lat_r;
   logic               addr_eff;
   logic               wr_act;
   logic               wr_act_r;
   logic               waddr_r;
   logic [DATA_W-1:0]  wdata_r;
   logic               commit;
   logic [PTR_W-1:0]   ptr_r;
   logic [NLINES-1:0]  line_en_r;
   logic               mask_r;
   logic [NLINES-1:0]  line_on;
   logic [NLINES-1:0]  ovl_flags_r;
   logic [NLINES-1:0]  line_sw_r;
   logic               data_oe_r;
   logic               int_oe_r;
   logic               int_n_r;

   read_port_if rp ();

   // two-stage synchroniser for every pin; first stage feeds only the second
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_NRST) begin
         sync1_r <= SYNC_RST;
         sync2_r <= SYNC_RST;
      end else if (I_CE) begin
         sync1_r <= {I_RESET, I_ALE, I_CS_N, I_RD_N, I_WR_N, I_ADDR_SELECT_BIT,
                     I_HOST_DATA_BUS, I_LOW_VOLT, I_OPEN_LOOP, I_CUR_OVL,
                     I_THERM_OVL};
         sync2_r <= sync1_r;
      end
   end

   // unpack the synchronised pins
   assign reset_s     = sync2_r[25];
   assign ale_s       = sync2_r[24];
   assign cs_n_s      = sync2_r[23];
   assign rd_n_s      = sync2_r[22];
   assign wr_n_s      = sync2_r[21];
   assign asel_s      = sync2_r[20];
   assign data_s      = sync2_r[19:16];
   assign low_volt_s  = sync2_r[15:12];
   assign open_loop_s = sync2_r[11:8];
   assign cur_ovl_s   = sync2_r[7:4];
   assign therm_ovl_s = sync2_r[3:0];

   // either the core reset or the device reset pin
   assign rst = !I_NRST || reset_s;

   // address latch: follows while strobe high, holds its last value after the fall
   always_ff @(posedge I_CORE_CLK) begin
      if (rst) begin
         addr_lat_r <= ADDR_PTR;
      end else if (I_CE && ale_s) begin
         addr_lat_r <= asel_s;
      end
   end

   // transparent path while the strobe is high, so a tied-high strobe works
   assign addr_eff = ale_s ? asel_s : addr_lat_r;

   // write strobe qualified by chip select
   assign wr_act = !wr_n_s && !cs_n_s;

   // data and address taken while the write is active; used at its end
   // sampling at the end honours the host data setup before the rising edge
   always_ff @(posedge I_CORE_CLK) begin
      if (rst) begin
         wr_act_r <= 1'b0;
         waddr_r  <= ADDR_PTR;
         wdata_r  <= 4'h0;
      end else if (I_CE) begin
         wr_act_r <= wr_act;
         if (wr_act) begin
            waddr_r <= addr_eff;
            wdata_r <= data_s;
         end
      end
   end

   // a write completes on the cycle its strobe or chip select goes inactive
   assign commit = wr_act_r && !wr_act;

   // indirect pointer and interrupt mask, both written at address 0
   always_ff @(posedge I_CORE_CLK) begin
      if (rst) begin
         ptr_r  <= PTR_RST;
         mask_r <= MASK_RST;
      end else if (I_CE && commit && waddr_r == ADDR_PTR) begin
         if (wdata_r[PTR_CMD_BIT]) begin
            mask_r <= wdata_r[MASK_BIT];
         end else begin
            ptr_r <= wdata_r[PTR_W-1:0];
         end
      end
   end

   // line enable register written at address 1
   always_ff @(posedge I_CORE_CLK) begin
      if (rst) begin
         line_en_r <= LINE_EN_RST;
      end else if (I_CE && commit && waddr_r == ADDR_DATA) begin
         line_en_r <= wdata_r[NLINES-1:0];
      end
   end

   // a line is powered when enabled and not in thermal shutdown
   assign line_on = line_en_r & ~therm_ovl_s;

   // switches and overload flags; flags drop when a line goes off
   always_ff @(posedge I_CORE_CLK) begin
      if (rst) begin
         line_sw_r   <= LINE_EN_RST;
         ovl_flags_r <= LINE_EN_RST;
      end else if (I_CE) begin
         line_sw_r   <= line_on;
         ovl_flags_r <= cur_ovl_s & line_on;
      end
   end

   // interrupt: unlatched, recomputed every cycle from the live flags
   // the pin only ever pulls low; the value output stays at zero
   always_ff @(posedge I_CORE_CLK) begin
      if (rst) begin
         int_oe_r <= 1'b0;
         int_n_r  <= 1'b0;
      end else if (I_CE) begin
         int_oe_r <= (|ovl_flags_r) && !mask_r;
         int_n_r  <= 1'b0;
      end
   end

   // data bus driven only during a selected read
   always_ff @(posedge I_CORE_CLK) begin
      if (rst) begin
         data_oe_r <= 1'b0;
      end else if (I_CE) begin
         data_oe_r <= !rd_n_s && !cs_n_s;
      end
   end

   // state handed to the read word selector
   assign rp.ce        = I_CE;
   assign rp.addr      = addr_eff;
   assign rp.ptr       = ptr_r;
   assign rp.low_volt  = low_volt_s;
   assign rp.open_loop = open_loop_s;
   assign rp.cur_ovl   = cur_ovl_s;
   assign rp.therm_ovl = therm_ovl_s;
   assign rp.line_en   = line_en_r;
   assign rp.ovl_flags = ovl_flags_r;
   assign rp.int_mask  = mask_r;

   read_select u_read_select (
      .clk (I_CORE_CLK),
      .rst (rst),
      .rp  (rp)
   );

   // outputs, each a register
   assign O_HOST_DATA_BUS   = rp.rdata;
   assign O_HOST_DATA_OE    = data_oe_r;
   assign O_INT_N           = int_n_r;
   assign O_INT_OE          = int_oe_r;
   assign O_LINE_SWITCH_OUT = line_sw_r;
endmodule

// >>> verification/feeder_assertions.sv
// Purpose: port assertions of the feeder host port
// Assumes: clock enable high, pins pass two sync flops
// Notes:   delays count sampled edges
module feeder_assertions (
   // clock and reset
   input wire logic                          I_CORE_CLK,
   input wire logic                          I_NRST,
   // pins
   input wire logic                          I_RESET,
   input wire logic                          I_CS_N,
   input wire logic                          I_RD_N,
   input wire logic [feeder_pkg::NLINES-1:0] I_CUR_OVL,
   input wire logic [feeder_pkg::NLINES-1:0] I_THERM_OVL,
   // outputs
   input wire logic                          O_HOST_DATA_OE,
   input wire logic                          O_INT_N,
   input wire logic                          O_INT_OE,
   input wire logic [feeder_pkg::NLINES-1:0] O_LINE_SWITCH_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   import feeder_pkg::*;
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_NRST);
   chk_oe_needs_read:
      assert property (O_HOST_DATA_OE |-> !$past(I_CS_N, 3) && !$past(I_RD_N, 3))
      else $error("bus driven without read");
   chk_oe_on_read:
      assert property ((!I_CS_N && !I_RD_N && !I_RESET) [*3] |=> O_HOST_DATA_OE)
      else $error("read not answered");
   chk_int_drive_low:
      assert property (!O_INT_N)
      else $error("open drain value high");
   chk_int_cause:
      assert property (O_INT_OE |-> ($past(I_CUR_OVL, 4) & $past(O_LINE_SWITCH_OUT)) != 4'h0)
      else $error("interrupt without overload");
   chk_therm_cut:
      assert property ((O_LINE_SWITCH_OUT & $past(I_THERM_OVL, 3)) == 4'h0)
      else $error("switch on during thermal");
   chk_pin_rst_int:
      assert property (I_RESET [*3] |=> !O_INT_OE && !O_HOST_DATA_OE)
      else $error("interrupt in reset");
   chk_pin_rst_sw:
      assert property (I_RESET [*3] |=> O_LINE_SWITCH_OUT == 4'h0)
      else $error("switch on in reset");
   chk_core_rst_out:
      assert property (disable iff (1'b0) !I_NRST |=> !O_INT_OE && O_LINE_SWITCH_OUT == 4'h0)
      else $error("outputs live in reset");
endmodule

bind line_feeder_host_interface feeder_assertions u_chk (.I_CORE_CLK, .I_NRST, .I_RESET,
   .I_CS_N, .I_RD_N, .I_CUR_OVL, .I_THERM_OVL, .O_HOST_DATA_OE, .O_INT_N, .O_INT_OE,
   .O_LINE_SWITCH_OUT);

// >>> verification/host_model.sv
// Purpose: host processor on the 4-bit bus
// Assumes: pins change 1 ns after a clock edge
// Notes:   released data shows the inverse of its last value
module host_model (
   // clock
   input wire logic                          i_clk,
   // bus pins
   output logic                              o_ale,
   output logic                              o_cs_n,
   output logic                              o_rd_n,
   output logic                              o_wr_n,
   output logic                              o_asel,
   output logic [feeder_pkg::DATA_W-1:0]     o_dq,
   input wire logic [feeder_pkg::DATA_W-1:0] i_dq
);
   timeunit 1ns;
   timeprecision 1ps;
   import feeder_pkg::*;
   logic [DATA_W-1:0] rdat;
   // idle bus, latch transparent
   initial begin
      {o_ale, o_cs_n, o_rd_n, o_wr_n, o_asel, o_dq} = 9'h1F0;
   end
   // 5 cycle strobe, all held to the sample edge
   task automatic acc(input logic wr, a, sel, input logic [DATA_W-1:0] d);
      @(posedge i_clk) #1;
      o_asel = a;
      o_dq = wr ? d : ~o_dq;
      o_cs_n = !sel;
      o_rd_n = wr;
      o_wr_n = !wr;
      repeat (5) @(posedge i_clk);
      rdat = i_dq;
      #1 {o_cs_n, o_rd_n, o_wr_n} = 3'h7;
      // data held one cycle past the strobe
      @(posedge i_clk) #1 o_dq = ~o_dq;
      repeat (4) @(posedge i_clk);
      // return off the edge so callers never race the sampling flops
      #1;
   endtask
   task automatic alat(input logic a, e);
      @(posedge i_clk) #1;
      o_asel = a;
      o_ale = e;
      repeat (4) @(posedge i_clk);
      #1;
   endtask
endmodule

// >>> verification/tb_top.sv
// Purpose: self-checking bench of the feeder host port
// Assumes: clock enable tied high
// Notes:   detectors change 1 ns after an edge
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import feeder_pkg::*;
   logic              clk = 1'b0, nrst = 1'b0, rpin = 1'b0;
   logic [NLINES-1:0] lv = 4'h0, ol = 4'h0, co = 4'h0, th = 4'h0, sw;
   logic [DATA_W-1:0] dout, bus, hdq, r;
   logic              ale, cs_n, rd_n, wr_n, asel, oe, int_n, int_oe;
   int                n_fail = 0, cmp_count = 0, cyc = 0;
   always #20 clk = ~clk;
   assign bus = oe ? dout : hdq;
   host_model u_h (.i_clk(clk), .o_ale(ale), .o_cs_n(cs_n), .o_rd_n(rd_n),
      .o_wr_n(wr_n), .o_asel(asel), .o_dq(hdq), .i_dq(bus));
   line_feeder_host_interface dut (.I_CORE_CLK(clk), .I_NRST(nrst), .I_CE(1'b1),
      .I_RESET(rpin), .I_ALE(ale), .I_CS_N(cs_n), .I_RD_N(rd_n), .I_WR_N(wr_n),
      .I_ADDR_SELECT_BIT(asel), .I_HOST_DATA_BUS(bus), .O_HOST_DATA_BUS(dout),
      .O_HOST_DATA_OE(oe), .O_INT_N(int_n), .O_INT_OE(int_oe), .I_LOW_VOLT(lv),
      .I_OPEN_LOOP(ol), .I_CUR_OVL(co), .I_THERM_OVL(th), .O_LINE_SWITCH_OUT(sw));
   task automatic chk(input logic [3:0] g, e);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic end_of_test;
      $display("fails %0d compares %0d", n_fail, cmp_count);
      if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // run needs about 480 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         end_of_test();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic a, input logic [3:0] d);
      u_h.acc(1'b1, a, 1'b1, d);
      tick(2);
   endtask
   task automatic rd(input logic a);
      u_h.acc(1'b0, a, 1'b1, 4'h0);
      r = u_h.rdat;
   endtask
   task automatic t_switch;
      chk({3'h0, int_oe}, 4'h0);
      rd(1'b0);
      chk(r, 4'h0);
      for (int i = 0; i < NLINES; i++) begin
         wr(1'b1, 4'h1 << i);
         chk(sw, 4'h1 << i);
      end
      wr(1'b1, 4'hA);
      wr(1'b0, 4'h4);
      rd(1'b1);
      chk(r, 4'hA);
      u_h.acc(1'b1, 1'b1, 1'b0, 4'h5);
      chk(sw, 4'hA);
   endtask
   task automatic t_status;
      {lv, ol, co, th} = 16'h1248;
      for (int i = 0; i < NLINES; i++) begin
         wr(1'b0, 4'(i));
         rd(1'b1);
         chk(r, {th[i], co[i], ol[i], lv[i]});
      end
      rd(1'b0);
      chk(r, 4'hB);
      chk(sw, 4'h2);
      wr(1'b0, 4'h7);
      rd(1'b1);
      chk(r, 4'h0);
      {lv, ol, co, th} = 16'h0;
   endtask
   task automatic t_int;
      wr(1'b1, 4'hF);
      co = 4'h4;
      tick(6);
      chk({2'h0, int_n, int_oe}, 4'h1);
      wr(1'b0, 4'h5);
      rd(1'b1);
      chk(r, 4'h4);
      wr(1'b0, 4'h9);
      chk({3'h0, int_oe}, 4'h0);
      rd(1'b0);
      chk(r, 4'h5);
      wr(1'b0, 4'h6);
      rd(1'b1);
      chk(r, 4'h1);
      wr(1'b0, 4'h8);
      chk({3'h0, int_oe}, 4'h1);
      th = 4'h4;
      tick(6);
      chk({3'h0, int_oe}, 4'h0);
      th = 4'h0;
      wr(1'b1, 4'hB);
      chk({3'h0, int_oe}, 4'h0);
      wr(1'b1, 4'hF);
      chk({3'h0, int_oe}, 4'h1);
      co = 4'h0;
      tick(6);
      chk({3'h0, int_oe}, 4'h0);
   endtask
   // latched address must outlive a changed address pin
   task automatic t_ale;
      wr(1'b0, 4'h4);
      u_h.alat(1'b1, 1'b1);
      u_h.alat(1'b1, 1'b0);
      u_h.acc(1'b0, 1'b0, 1'b1, 4'h0);
      chk(u_h.rdat, 4'hF);
      u_h.alat(1'b0, 1'b1);
   endtask
   task automatic t_pinrst;
      co = 4'h1;
      tick(6);
      rpin = 1'b1;
      tick(4);
      chk(sw, 4'h0);
      chk({3'h0, int_oe}, 4'h0);
      rpin = 1'b0;
      tick(4);
      rd(1'b1);
      chk(r, 4'h4);
      wr(1'b0, 4'h4);
      rd(1'b1);
      chk(r, 4'h0);
      co = 4'h0;
   endtask
   initial begin
      tick(5);
      nrst = 1'b1;
      tick(2);
      t_switch();
      t_status();
      t_int();
      t_ale();
      t_pinrst();
      end_of_test();
   end
endmodule
